// file: src/fbo_host_ctrl.sv
// host-side controller that drives a parallel flash through its pins
// Overview of operation
// - commands are plain address/data bus writes
// - reset command returns device to read
// - read: select low, output enable low
// - write: select low, write strobe low
// - byte mode puts byte address on line 15
// - address runs to bit 0 or extra bit
`timescale 1ns/100ps
module fbo_host_ctrl
   import fbo_pkg::*;
#(
   parameter int ADDR_W  = ADDR_W_DEF,
   parameter bit WP_TOP  = 1'b1        // outermost sector is the highest one
) (
   // clock and reset
   input  wire logic              core_clk_i,
   input  wire logic              rst_n_i,
   // user request
   input  wire logic              req_valid_i,
   input  wire logic [1:0]        req_op_i,
   input  wire logic [ADDR_W:0]   req_addr_i,     // byte address, bit 0 used in byte mode
   input  wire logic [15:0]       req_data_i,
   output logic                   req_ready_o,
   // user answer and settings
   output logic                   rsp_valid_o,
   output logic [15:0]            rsp_data_o,
   output logic                   prot_err_o,
   input  wire logic              byte_mode_i,
   input  wire logic              wp_release_i,
   // flash pins
   output logic                   chip_sel_n_o,
   output logic                   out_en_n_o,
   output logic                   wr_strobe_n_o,
   output logic                   hw_reset_n_o,
   output logic                   write_protect_accel_n_o,
   output logic                   width_sel_n_o,
   output logic [ADDR_W-1:0]      addr_o,
   output logic [15:0]            data_lines_o,
   output logic [15:0]            data_lines_oe_o,
   input  wire logic [15:0]       data_lines_i
);
   localparam int SECT_W = ADDR_W - SECT_WORD_BITS;

   // refuse geometries outside 128..1024 sectors
   if (ADDR_W < ADDR_W_MIN || ADDR_W > ADDR_W_MAX) begin : g_bad_addr_w
      $error("ADDR_W outside supported sector range");
   end
   if (READ_CYC < 1 || WE_CYC < 1 || RESET_CYC < 1 || RESET_REC_CYC < 1 || RESET_CYC > 255) begin : g_bad_tmr
      $error("timing counts do not fit the timer");
   end

   typedef struct packed {
      fbo_state_t         st;
      logic               ready;
      logic               rsp_valid;
      logic [15:0]        rsp_data;
      logic               prot_err;
      logic               ce_n;
      logic               oe_n;
      logic               we_n;
      logic               rst_n;
      logic               wp_n;
      logic               byte_n;
      logic [ADDR_W-1:0]  addr;
      logic [15:0]        dq;
      logic [15:0]        dq_oe;
   } fbo_host_t;

   fbo_host_t r;
   fbo_host_t next_r;
   logic              tmr_load;
   logic [TMR_W-1:0]  tmr_val;
   logic              tmr_done;

   // sector index from a word address
   function automatic logic [SECT_W-1:0] sector_of(input logic [ADDR_W-1:0] a);
      return a[ADDR_W-1:SECT_WORD_BITS];
   endfunction : sector_of

   // true when the pin-guarded sector is targeted
   function automatic logic is_outer(input logic [ADDR_W-1:0] a);
      return WP_TOP ? (sector_of(a) == '1) : (sector_of(a) == '0);
   endfunction : is_outer

   // enables for a cycle: low byte always in write, upper per width, line 15 as address in byte mode
   function automatic logic [15:0] drive_mask(input logic bytem, input logic wr);
      logic [15:0] m;
      m = '0;
      if (wr) begin
         m[BYTE_MSB:0] = '1;
         if (!bytem) begin
            m[15:BYTE_MSB+1] = '1;
         end
      end
      if (bytem) begin
         m[ADDR_LSB_LINE] = 1'b1;
      end
      return m;
   endfunction : drive_mask

   fbo_wait_timer #(
      .W (TMR_W)
   ) u_tmr (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .load_i     (tmr_load),
      .count_i    (tmr_val),
      .done_o     (tmr_done)
   );

   // next state: one bus operation at a time, sequenced by the timer
   always_comb begin
      next_r    = r;
      tmr_load  = 1'b0;
      tmr_val   = '0;
      next_r.rsp_valid = 1'b0;
      next_r.prot_err  = 1'b0;
      unique case (r.st)
         ST_IDLE: begin
            // standby: select high, nothing driven
            next_r.ce_n  = 1'b1;
            next_r.oe_n  = 1'b1;
            next_r.we_n  = 1'b1;
            next_r.dq_oe = '0;
            next_r.byte_n = !byte_mode_i;
            next_r.wp_n   = wp_release_i;
            next_r.ready  = 1'b1;
            if (req_valid_i && r.ready) begin
               next_r.addr = req_addr_i[ADDR_W:1];
               next_r.dq   = {req_addr_i[0], req_data_i[14:0]};
               if (!byte_mode_i) begin
                  next_r.dq[ADDR_LSB_LINE] = req_data_i[ADDR_LSB_LINE];
               end
               unique case (fbo_op_t'(req_op_i))
                  FBO_OP_READ: begin
                     next_r.st    = ST_READ;
                     next_r.ready = 1'b0;
                     next_r.ce_n  = 1'b0;
                     next_r.oe_n  = 1'b0;
                     next_r.dq_oe = drive_mask(byte_mode_i, 1'b0);
                     tmr_load     = 1'b1;
                     tmr_val      = TMR_W'(READ_CYC - 1);
                  end
                  FBO_OP_WRITE, FBO_OP_RSTCMD: begin
                     if (fbo_op_t'(req_op_i) == FBO_OP_WRITE && !wp_release_i
                         && is_outer(req_addr_i[ADDR_W:1])) begin
                        // guarded sector: refuse without touching the bus
                        next_r.prot_err = 1'b1;
                     end else begin
                        if (fbo_op_t'(req_op_i) == FBO_OP_RSTCMD) begin
                           next_r.dq[BYTE_MSB:0] = RESET_CMD_DATA[BYTE_MSB:0];
                           if (!byte_mode_i) begin
                              next_r.dq[15:BYTE_MSB+1] = RESET_CMD_DATA[15:BYTE_MSB+1];
                           end
                        end
                        next_r.st    = ST_WRITE;
                        next_r.ready = 1'b0;
                        next_r.ce_n  = 1'b0;
                        next_r.we_n  = 1'b0;
                        next_r.dq_oe = drive_mask(byte_mode_i, 1'b1);
                        tmr_load     = 1'b1;
                        tmr_val      = TMR_W'(WE_CYC - 1);
                     end
                  end
                  FBO_OP_HWRST: begin
                     next_r.st    = ST_HWRST;
                     next_r.ready = 1'b0;
                     next_r.rst_n = 1'b0;
                     next_r.dq_oe = '0;
                     tmr_load     = 1'b1;
                     tmr_val      = TMR_W'(RESET_CYC - 1);
                  end
               endcase
            end
         end
         ST_READ: begin
            if (tmr_done) begin
               next_r.st        = ST_IDLE;
               next_r.rsp_valid = 1'b1;
               next_r.rsp_data  = r.byte_n ? data_lines_i : {8'h00, data_lines_i[BYTE_MSB:0]};
               next_r.ce_n      = 1'b1;
               next_r.oe_n      = 1'b1;
               next_r.dq_oe     = '0;
            end
         end
         ST_WRITE: begin
            // strobe rises with data still held, so the device latches it
            if (tmr_done) begin
               next_r.st   = ST_WHOLD;
               next_r.we_n = 1'b1;
            end
         end
         ST_WHOLD: begin
            next_r.st    = ST_IDLE;
            next_r.ce_n  = 1'b1;
            next_r.dq_oe = '0;
         end
         ST_HWRST: begin
            if (tmr_done) begin
               next_r.st    = ST_RREC;
               next_r.rst_n = 1'b1;
               tmr_load     = 1'b1;
               tmr_val      = TMR_W'(RESET_REC_CYC - 1);
            end
         end
         ST_RREC: begin
            if (tmr_done) begin
               next_r.st = ST_IDLE;
            end
         end
         default: begin
            next_r.st = ST_IDLE;
         end
      endcase
   end

   // all pins and answers come straight from this register
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         r          <= '0;
         r.st       <= ST_IDLE;
         r.ce_n     <= 1'b1;
         r.oe_n     <= 1'b1;
         r.we_n     <= 1'b1;
         r.rst_n    <= 1'b1;
         r.wp_n     <= 1'b1;
         r.byte_n   <= 1'b1;
         r.dq       <= DATA_RST;
      end else begin
         r <= next_r;
      end
   end

   assign req_ready_o             = r.ready;
   assign rsp_valid_o             = r.rsp_valid;
   assign rsp_data_o              = r.rsp_data;
   assign prot_err_o              = r.prot_err;
   assign chip_sel_n_o            = r.ce_n;
   assign out_en_n_o              = r.oe_n;
   assign wr_strobe_n_o           = r.we_n;
   assign hw_reset_n_o            = r.rst_n;
   assign write_protect_accel_n_o = r.wp_n;
   assign width_sel_n_o           = r.byte_n;
   assign addr_o                  = r.addr;
   assign data_lines_o            = r.dq;
   assign data_lines_oe_o         = r.dq_oe;

   // checks on the pin sequencing
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);

   logic [TMR_W-1:0] we_low_cnt;
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         we_low_cnt <= '0;
      end else begin
         we_low_cnt <= r.we_n ? '0 : we_low_cnt + 1'b1;
      end
   end

   chk_read_strobes: assert property (!r.oe_n |-> !r.ce_n && r.we_n && r.rst_n)
      else $error("read without proper strobes");
   chk_write_strobes: assert property (!r.we_n |-> !r.ce_n && r.oe_n && r.rst_n)
      else $error("write without proper strobes");
   chk_no_contention: assert property (!r.oe_n |-> r.dq_oe[14:0] == '0)
      else $error("host drives data while device may output");
   chk_we_pulse_len: assert property ($rose(r.we_n) |-> we_low_cnt == TMR_W'(WE_CYC))
      else $error("write strobe width wrong");
   chk_byte_mid_hiz: assert property (!r.byte_n |-> r.dq_oe[14:BYTE_MSB+1] == '0)
      else $error("byte mode drives lines 8-14");
   chk_byte_addr_bit: assert property (!r.byte_n && !r.ce_n |-> r.dq_oe[ADDR_LSB_LINE])
      else $error("byte address line not driven");
   chk_reset_quiet: assert property (!r.rst_n |-> r.ce_n && r.oe_n && r.we_n && r.dq_oe == '0)
      else $error("activity during hardware reset");
   chk_standby_idle: assert property (r.ce_n |-> r.dq_oe == '0 && r.we_n && r.oe_n)
      else $error("drive while deselected");
   chk_wp_refuse: assert property (req_valid_i && r.ready && req_op_i == FBO_OP_WRITE && !wp_release_i
      && is_outer(req_addr_i[ADDR_W:1]) |=> prot_err_o && r.we_n)
      else $error("guarded sector write not refused");
   chk_reset_cmd: assert property ($fell(r.we_n) && r.dq[BYTE_MSB:0] == RESET_CMD_DATA[BYTE_MSB:0]
      |-> r.dq_oe[BYTE_MSB:0] == '1)
      else $error("command byte not driven");
   chk_read_answer: assert property ($fell(r.oe_n) |-> ##[1:255] rsp_valid_o)
      else $error("read never answered");

   cov_read:    cover property (rsp_valid_o);
   cov_write:   cover property ($rose(r.we_n));
   cov_hwrst:   cover property ($rose(r.rst_n));
   cov_prot:    cover property (prot_err_o);
endmodule : fbo_host_ctrl

// file: src/fbo_pkg.sv
// package: constants and types for the parallel flash host controller
package fbo_pkg;
   // clock and bus geometry
   localparam int CLK_PERIOD_NS  = 10;
   localparam int ADDR_W_DEF     = 26;              // word address bits for 1024 sectors
   localparam int ADDR_W_MIN     = 23;              // 128 sectors
   localparam int ADDR_W_MAX     = 26;              // 1024 sectors
   localparam int SECT_WORD_BITS = 16;              // 64K words per sector
   localparam int DATA_W         = 16;
   localparam int BYTE_MSB       = 7;               // top bit of the byte lane
   localparam int ADDR_LSB_LINE  = 15;              // data line reused as byte address
   // bus timing in ns (plain defaults) and derived cycle counts, rounded up
   localparam int READ_ACC_NS    = 110;
   localparam int WE_LOW_NS      = 35;
   localparam int RESET_LOW_NS   = 500;
   localparam int RESET_REC_NS   = 50;
   localparam int READ_CYC       = (READ_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WE_CYC         = (WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RESET_CYC      = (RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RESET_REC_CYC  = (RESET_REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TMR_W          = 8;
   // command data and reset values
   localparam logic [15:0] RESET_CMD_DATA = 16'h00F0;
   localparam logic [15:0] DATA_RST       = 16'h0000;
   // user operations
   typedef enum logic [1:0] {
      FBO_OP_READ   = 2'h0,
      FBO_OP_WRITE  = 2'h1,
      FBO_OP_RSTCMD = 2'h2,
      FBO_OP_HWRST  = 2'h3
   } fbo_op_t;
   // controller states, one-hot
   typedef enum logic [5:0] {
      ST_IDLE  = 6'h01,
      ST_READ  = 6'h02,
      ST_WRITE = 6'h04,
      ST_WHOLD = 6'h08,
      ST_HWRST = 6'h10,
      ST_RREC  = 6'h20
   } fbo_state_t;
endpackage : fbo_pkg

// file: src/fbo_wait_timer.sv
// down-counter that paces the flash bus phases
`timescale 1ns/100ps
module fbo_wait_timer
   import fbo_pkg::*;
#(
   parameter int W = TMR_W
) (
   // clock and reset
   input  wire logic         core_clk_i,
   input  wire logic         rst_n_i,
   // control
   input  wire logic         load_i,
   input  wire logic [W-1:0] count_i,
   // status
   output logic              done_o
);
   typedef struct packed {
      logic [W-1:0] cnt;
   } fbo_tmr_t;

   fbo_tmr_t r;
   fbo_tmr_t next_r;

   // load wins over counting so a new phase always restarts cleanly
   always_comb begin
      next_r = r;
      if (load_i) begin
         next_r.cnt = count_i;
      end else if (r.cnt != '0) begin
         next_r.cnt = r.cnt - 1'b1;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // done reads the register alone: a caller that loads on done must not see done fall in the same cycle
   assign done_o = (r.cnt == '0);
endmodule : fbo_wait_timer

// file: tb/fbo_flash_model.sv
// behavioural parallel flash device driven through its pins; the bench also reads its command latch, buffer and counters
`timescale 1ns/100ps
module fbo_flash_model
   import fbo_pkg::*;
#(
   parameter int ADDR_W = ADDR_W_DEF,
   parameter int ACC_NS = 80
) (
   // control pins
   input  wire logic              chip_sel_n_i,
   input  wire logic              out_en_n_i,
   input  wire logic              wr_strobe_n_i,
   input  wire logic              hw_reset_n_i,
   input  wire logic              write_protect_accel_n_i,
   input  wire logic              width_sel_n_i,
   // address and resolved data lines
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [15:0]       data_lines_i,
   output logic      [15:0]       data_lines_o,
   output logic      [15:0]       data_lines_oe_o
);
   logic [15:0]       rd_word;
   logic              acc_ok    = 1'b0;
   logic [ADDR_W-1:0] cmd_addr  = '0;
   logic [15:0]       cmd_data  = 16'h0000;
   logic              cmd_lsb   = 1'b0;
   logic              read_mode = 1'b1;
   int                wr_cnt    = 0;
   int                prot_hit  = 0;
   localparam int SECURE_WORDS = 128;   // one-time region size; this host never addresses it
   localparam int BUF_WORDS    = 32;    // deepest buffered program the device accepts
   // recent program words, kept the way a buffered program would hold them
   logic [15:0]       wbuf [BUF_WORDS];
   // array content is a fixed function of the word address
   assign rd_word = addr_i[15:0] ^ 16'hC35A;
   // drive only on a true read; byte mode keeps lines 8-14 quiet
   assign data_lines_oe_o = (!chip_sel_n_i && !out_en_n_i && wr_strobe_n_i && hw_reset_n_i)
                            ? (width_sel_n_i ? 16'hFFFF : 16'h00FF) : 16'h0000;
   // before the access time the lines show garbage, never the right word
   assign data_lines_o = !acc_ok ? ~rd_word : width_sel_n_i ? rd_word
                         : {8'h00, data_lines_i[15] ? rd_word[15:8] : rd_word[7:0]};
   // data settles only an access time after select and output enable
   always @(out_en_n_i or chip_sel_n_i or addr_i) begin
      acc_ok = 1'b0;
      if (!out_en_n_i && !chip_sel_n_i) begin
         #(ACC_NS) acc_ok = !out_en_n_i;
      end
   end
   // command latch loads on the rising strobe while selected, outside reset
   always @(posedge wr_strobe_n_i) begin
      if (!chip_sel_n_i && hw_reset_n_i) begin
         cmd_addr = addr_i;
         cmd_data = width_sel_n_i ? data_lines_i : {8'h00, data_lines_i[7:0]};
         cmd_lsb  = width_sel_n_i ? 1'b0 : data_lines_i[15];
         wbuf[wr_cnt % BUF_WORDS] = cmd_data;
         wr_cnt++;
         if ((&addr_i[ADDR_W-1:16]) && !write_protect_accel_n_i) prot_hit++;
         read_mode = (cmd_data[7:0] == 8'hF0);
      end
   end
endmodule : fbo_flash_model

// file: tb/fbo_host_ctrl_tb.sv
// self-checking bench for the parallel flash host controller
`timescale 1ns/100ps
module fbo_host_ctrl_tb;
   import fbo_pkg::*;
   localparam int AW = ADDR_W_DEF;
   // stimulus, pins and bookkeeping
   logic          core_clk_i, rst_n_i, req_valid_i, byte_mode_i, wp_release_i;
   logic [1:0]    req_op_i;
   logic [AW:0]   req_addr_i;
   logic [15:0]   req_data_i, rsp_data_o, h_d, h_oe, d_d, d_oe, bus, flt, s_oe, s_dq;
   logic          req_ready_o, rsp_valid_o, prot_err_o, cs_n, oe_n, we_n, hr_n, wp_n, ws_n, cs_bad, got_prot;
   logic [AW-1:0] addr, s_addr;
   logic [3:0]    s_pins;
   int            error_cnt = 0;
   int            checks_done = 0;
   int            lat, rst_low;

   fbo_host_ctrl u_dut (
      .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i), .req_op_i(req_op_i),
      .req_addr_i(req_addr_i), .req_data_i(req_data_i), .req_ready_o(req_ready_o),
      .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .prot_err_o(prot_err_o),
      .byte_mode_i(byte_mode_i), .wp_release_i(wp_release_i), .chip_sel_n_o(cs_n), .out_en_n_o(oe_n),
      .wr_strobe_n_o(we_n), .hw_reset_n_o(hr_n), .write_protect_accel_n_o(wp_n), .width_sel_n_o(ws_n),
      .addr_o(addr), .data_lines_o(h_d), .data_lines_oe_o(h_oe), .data_lines_i(bus)
   );
   fbo_flash_model #(.ADDR_W(AW), .ACC_NS(80)) u_flash (
      .chip_sel_n_i(cs_n), .out_en_n_i(oe_n), .wr_strobe_n_i(we_n), .hw_reset_n_i(hr_n),
      .write_protect_accel_n_i(wp_n), .width_sel_n_i(ws_n), .addr_i(addr), .data_lines_i(bus),
      .data_lines_o(d_d), .data_lines_oe_o(d_oe)
   );
   // resolved lines; undriven bits show a toggling pattern, not a stale value
   assign bus = (h_oe & h_d) | (~h_oe & d_oe & d_d) | (~h_oe & ~d_oe & flt);

   initial begin
      core_clk_i = 1'b0;
      forever #(CLK_PERIOD_NS / 2) core_clk_i = ~core_clk_i;
   end
   // two drivers on one line is a fault at any time
   always @(negedge core_clk_i) begin
      flt <= ~flt;
      if ((h_oe & d_oe) !== 16'h0000) begin
         error_cnt++;
         $display("unexpected bus_conflict: expected 0000, seen %h", h_oe & d_oe);
      end
   end

   function automatic logic [15:0] pat(input logic [AW-1:0] a);
      return a[15:0] ^ 16'hC35A;
   endfunction : pat

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chk

   // one request: wait for ready, hold valid over the take edge, then follow the phase
   task automatic do_op(input logic [1:0] o, input logic [AW:0] a, input logic [15:0] d);
      int n;
      n = 0;
      while (req_ready_o !== 1'b1 && n < 100) begin
         @(negedge core_clk_i);
         n++;
      end
      req_valid_i = 1'b1;
      req_op_i = o;
      req_addr_i = a;
      req_data_i = d;
      @(negedge core_clk_i);
      req_valid_i = 1'b0;
      lat = 0;
      rst_low = 0;
      cs_bad = 1'b0;
      // the refusal pulse and the first reset cycle stand right after the take edge
      got_prot = prot_err_o;
      if (!hr_n) rst_low++;
      do begin
         @(negedge core_clk_i);
         lat++;
         if (prot_err_o === 1'b1) got_prot = 1'b1;
         if (lat == 2) begin
            s_pins = {cs_n, oe_n, we_n, hr_n};
            s_oe = h_oe;
            s_dq = h_d;
            s_addr = addr;
         end
         if (!hr_n) rst_low++;
         if (!hr_n && !cs_n) cs_bad = 1'b1;
      end while (rsp_valid_o !== 1'b1 && prot_err_o !== 1'b1 && req_ready_o !== 1'b1 && lat < 100);
   endtask : do_op

   // mode inputs are only sampled in idle, so give them a few cycles
   task automatic set_mode(input logic b, input logic w);
      byte_mode_i = b;
      wp_release_i = w;
      repeat (3) @(negedge core_clk_i);
   endtask : set_mode

   task automatic t_word_read(input logic [AW-1:0] a);
      do_op(2'h0, {a, 1'b0}, 16'h0000);
      chk("read_lat", READ_CYC, lat);
      chk("read_pins", 4'h3, s_pins);
      chk("read_oe", 16'h0000, s_oe);
      chk("read_addr", a, s_addr);
      chk("read_data", pat(a), rsp_data_o);
   endtask : t_word_read

   task automatic t_write(input logic [AW-1:0] a, input logic [15:0] d, input logic prot);
      int c;
      c = u_flash.wr_cnt;
      do_op(2'h1, {a, 1'b0}, d);
      if (prot) begin
         chk("prot_err", 1, got_prot);
         chk("prot_writes", c, u_flash.wr_cnt);
      end else begin
         chk("no_prot_err", 0, got_prot);
         chk("write_lat", WE_CYC + 2, lat);
         chk("write_pins", 4'h5, s_pins);
         chk("write_dq", d, s_dq);
         chk("latch_addr", a, u_flash.cmd_addr);
         chk("latch_data", d, u_flash.cmd_data);
         chk("buf_word", d, u_flash.wbuf[(u_flash.wr_cnt - 1) % 32]);
      end
   endtask : t_write

   task automatic t_rstcmd;
      chk("mode_before", 0, u_flash.read_mode);
      do_op(2'h2, '0, 16'h0000);
      chk("rst_cmd_data", RESET_CMD_DATA, u_flash.cmd_data);
      chk("read_mode", 1, u_flash.read_mode);
   endtask : t_rstcmd

   task automatic t_protect;
      set_mode(1'b0, 1'b0);
      chk("wp_pin_low", 0, wp_n);
      t_write({AW{1'b1}}, 16'h1357, 1'b1);
      t_write(26'h0000042, 16'h2468, 1'b0);
      set_mode(1'b0, 1'b1);
      chk("wp_pin_high", 1, wp_n);
      t_write({AW{1'b1}}, 16'h1357, 1'b0);
   endtask : t_protect

   task automatic t_byte(input logic [AW-1:0] a);
      logic [15:0] w;
      w = pat(a);
      set_mode(1'b1, 1'b1);
      chk("width_pin", 0, ws_n);
      for (int b = 0; b < 2; b++) begin
         do_op(2'h0, {a, b[0]}, 16'h0000);
         chk("byte_oe", 16'h8000, s_oe);
         chk("byte_a1", b[0], s_dq[15]);
         chk("byte_data", {8'h00, b[0] ? w[15:8] : w[7:0]}, rsp_data_o);
      end
      do_op(2'h1, {a, 1'b1}, 16'hBE5A);
      chk("byte_wr_data", 16'h005A, u_flash.cmd_data);
      chk("byte_wr_lsb", 1, u_flash.cmd_lsb);
      set_mode(1'b0, 1'b1);
   endtask : t_byte

   task automatic t_hwrst;
      do_op(2'h3, '0, 16'h0000);
      chk("reset_low_cycles", RESET_CYC, rst_low);
      chk("select_in_reset", 0, cs_bad);
      chk("idle_pins", 4'hF, {cs_n, oe_n, we_n, hr_n});
      chk("idle_oe", 16'h0000, h_oe);
   endtask : t_hwrst

   task automatic close_out;
      $display("checks %0d, errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : close_out

   // main sequence
   initial begin
      flt = 16'h5A5A;
      rst_n_i = 1'b0;
      req_valid_i = 1'b0;
      req_op_i = 2'h0;
      req_addr_i = '0;
      req_data_i = 16'h0000;
      byte_mode_i = 1'b0;
      wp_release_i = 1'b0;
      repeat (12) @(negedge core_clk_i);
      rst_n_i = 1'b1;
      repeat (2) @(negedge core_clk_i);
      chk("ready_idle", 1, req_ready_o);
      t_word_read('0);
      t_word_read({AW{1'b1}});
      t_write(26'h0051234, 16'hA55A, 1'b0);
      t_rstcmd;
      t_protect;
      t_byte(26'h1230077);
      t_hwrst;
      t_word_read(26'h0010000);
      chk("protected_writes", 0, u_flash.prot_hit);
      close_out;
   end
   // hang guard, far beyond the few hundred cycles the tests need
   initial begin
      #(5000 * CLK_PERIOD_NS);
      error_cnt++;
      close_out;
   end
endmodule : fbo_host_ctrl_tb
